// [hdl/spe_map.vh]
// Register map, field positions and reset values of the serial port.
// Assumes a 32-bit APB with byte addresses; registers sit in the low 16 bits.
`ifndef SPE_MAP_VH
`define SPE_MAP_VH

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define SPE_OFF_CTRL1   8'h00
`define SPE_OFF_CTRL2   8'h04
`define SPE_OFF_STAT    8'h08
`define SPE_OFF_BUF     8'h0C
`define SPE_OFF_ISTAT   8'h10
`define SPE_OFF_ICLR    8'h14
`define SPE_OFF_IEN     8'h18

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define SPE_C1_PRI_LSB  0
`define SPE_C1_SEC_LSB  2
`define SPE_C1_MASTER   5
`define SPE_C1_IDLE_HI  6
`define SPE_C1_SS_EN    7
`define SPE_C1_EDGE     8
`define SPE_C1_SAMPLE   9
`define SPE_C1_SDO_DIS  11
`define SPE_C1_SCK_DIS  12
`define SPE_C2_BUF_ENH  0
`define SPE_C2_FRAMED   15
`define SPE_ST_RX_AVAIL 0
`define SPE_ST_TX_FULL  1
`define SPE_ST_OVF      6
`define SPE_ST_ON       15
`define SPE_EV_DONE     0
`define SPE_EV_OVF      1
`define SPE_EV_TXE      2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SPE_RST_CTRL1   16'h0000
`define SPE_RST_CTRL2   16'h0000
`define SPE_RST_EVT     3'h0

`endif

// [hdl/spe_clkdiv.v]
// Master serial clock prescaler: one tick pulse per primary x secondary cycles.
// Assumes en is held high for the whole of a master transfer.
`timescale 1ns/1ps
`default_nettype none

module spe_clkdiv (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       en,
  input  wire [1:0] pri,
  input  wire [2:0] sec,
  output reg        tick
);

  reg  [9:0] cnt_r;
  wire [9:0] lim;

  // ----------------------------------------------------------------------------
  // Ratio arithmetic
  // ----------------------------------------------------------------------------
  function [9:0] ratio_m1;
    input [1:0] p;
    input [2:0] s;
    reg   [6:0] pr;
    reg   [3:0] sr;
    reg   [10:0] prod;
    begin
      case (p)
        2'h3:    pr = 7'h01;
        2'h2:    pr = 7'h04;
        2'h1:    pr = 7'h10;
        default: pr = 7'h40;
      endcase
      sr = 4'h8 - {1'b0, s};
      prod = pr * sr;
      ratio_m1 = prod[9:0] - 10'h001;
    end
  endfunction

  assign lim = ratio_m1(pri, sec);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 10'h000;
      tick  <= 1'b0;
    end else if (!en) begin
      cnt_r <= 10'h000;
      tick  <= 1'b0;
    end else if (cnt_r >= lim) begin
      cnt_r <= 10'h000;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 10'h001;
      tick  <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [hdl/spe_port.v]
// Serial peripheral port: APB registers, transmit/receive buffers, shifter.
// Assumes pins arrive asynchronous to ref_clk and software follows bring-up order.
`timescale 1ns/1ps
`default_nettype none
`include "spe_map.vh"

module spe_port #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        sck_in,
  input  wire        sdi_in,
  input  wire        ss_in_n,
  output reg         sck_out,
  output reg         sck_oe,
  output reg         sdo_out,
  output reg         sdo_oe,
  output reg         ss_out_n,
  output reg         irq
);

  localparam S_IDLE = 2'b01;
  localparam S_XFER = 2'b10;

  reg  [15:0]      ctrl1_r;
  reg  [15:0]      ctrl2_r;
  reg              on_r;
  reg              ovf_r;
  reg  [2:0]       ien_r;
  reg  [2:0]       ist_r;
  reg  [1:0]       state_r;
  reg  [WIDTH-1:0] sreg_r;
  reg  [4:0]       cnt_r;
  reg              ld_r;
  reg  [1:0]       sck_sy_r;
  reg  [1:0]       sdi_sy_r;
  reg  [1:0]       ss_sy_r;
  reg              sck_d_r;
  reg  [WIDTH-1:0] txm [0:DEPTH-1];
  reg  [WIDTH-1:0] rxm [0:DEPTH-1];
  reg  [AW-1:0]    tx_wp_r;
  reg  [AW-1:0]    tx_rp_r;
  reg  [AW:0]      tx_cnt_r;
  reg  [AW-1:0]    rx_wp_r;
  reg  [AW-1:0]    rx_rp_r;
  reg  [AW:0]      rx_cnt_r;
  reg  [15:0]      rdata_c;
  reg              hit_c;
  wire             tick;

  // ----------------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------------
  wire master  = ctrl1_r[`SPE_C1_MASTER];
  wire idle_hi = ctrl1_r[`SPE_C1_IDLE_HI];
  wire ss_en   = ctrl1_r[`SPE_C1_SS_EN];
  wire framed  = ctrl2_r[`SPE_C2_FRAMED];
  wire cke_eff = ctrl1_r[`SPE_C1_EDGE] & ~framed;
  wire benh    = ctrl2_r[`SPE_C2_BUF_ENH];
  // Single-buffer mode caps both queues at one word.
  wire [AW:0] cap = benh ? DEPTH[AW:0] : {{AW{1'b0}}, 1'b1};
  wire tx_full = tx_cnt_r >= cap;
  wire rx_full = rx_cnt_r >= cap;
  wire tx_any  = tx_cnt_r != {(AW+1){1'b0}};
  wire rx_any  = rx_cnt_r != {(AW+1){1'b0}};

  function [AW-1:0] nxt_ptr;
    input [AW-1:0] p;
    begin
      nxt_ptr = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  // ----------------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------------
  wire acc  = psel & penable & ~pready;
  wire done = psel & penable & pready;
  wire wr   = done & pwrite;
  wire rd   = done & ~pwrite;

  always @* begin
    rdata_c = 16'h0000;
    hit_c   = 1'b1;
    case (paddr)
      `SPE_OFF_CTRL1: rdata_c = ctrl1_r;
      `SPE_OFF_CTRL2: rdata_c = ctrl2_r;
      `SPE_OFF_STAT: begin
        rdata_c[`SPE_ST_ON]       = on_r;
        rdata_c[`SPE_ST_OVF]      = ovf_r;
        rdata_c[`SPE_ST_TX_FULL]  = tx_full;
        rdata_c[`SPE_ST_RX_AVAIL] = rx_any;
      end
      `SPE_OFF_BUF:   rdata_c[WIDTH-1:0] = rxm[rx_rp_r];
      `SPE_OFF_ISTAT: rdata_c[2:0] = ist_r;
      `SPE_OFF_ICLR:  rdata_c = 16'h0000;
      `SPE_OFF_IEN:   rdata_c[2:0] = ien_r;
      default:        hit_c = 1'b0;
    endcase
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~hit_c;
      if (acc) begin
        prdata <= {16'h0000, rdata_c};
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sck_sy_r <= 2'h0;
      sdi_sy_r <= 2'h0;
      ss_sy_r  <= 2'h3;
      sck_d_r  <= 1'b0;
    end else begin
      sck_sy_r <= {sck_sy_r[0], sck_in};
      sdi_sy_r <= {sdi_sy_r[0], sdi_in};
      ss_sy_r  <= {ss_sy_r[0], ss_in_n};
      sck_d_r  <= sck_sy_r[1];
    end
  end

  // ----------------------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------------------
  wire run_m    = on_r & master;
  wire run_s    = on_r & ~master & (~ss_en | ~ss_sy_r[1]);
  wire sck_edge = sck_sy_r[1] ^ sck_d_r;
  wire lead     = run_m ? (tick & (state_r == S_XFER) & (sck_out == idle_hi))
                        : (run_s & sck_edge & (sck_sy_r[1] != idle_hi));
  wire trail    = run_m ? (tick & (state_r == S_XFER) & (sck_out != idle_hi))
                        : (run_s & sck_edge & (sck_sy_r[1] == idle_hi));
  wire samp_p   = cke_eff ? lead : trail;
  wire chg_p    = cke_eff ? trail : lead;
  wire last     = cnt_r == (WIDTH - 1);
  wire word_end = samp_p & last;
  wire fin      = trail & (cke_eff ? (cnt_r == WIDTH) : last);
  wire m_load   = run_m & (state_r == S_IDLE) & tx_any;
  wire s_load   = on_r & ~master & ~ld_r & tx_any & (cnt_r == 5'h00);
  wire tx_pop   = m_load | s_load;
  wire tx_push  = wr & (paddr == `SPE_OFF_BUF) & ~tx_full;
  wire rx_push  = word_end & ~rx_full;
  wire rx_pop   = rd & (paddr == `SPE_OFF_BUF) & rx_any;
  wire [WIDTH-1:0] nxt_word = {sreg_r[WIDTH-2:0], sdi_sy_r[1]};

  spe_clkdiv u_div (
    .ref_clk (ref_clk),
    .rst     (rst),
    .en      (run_m & (state_r == S_XFER)),
    .pri     (ctrl1_r[`SPE_C1_PRI_LSB +: 2]),
    .sec     (ctrl1_r[`SPE_C1_SEC_LSB +: 3]),
    .tick    (tick)
  );

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r  <= S_IDLE;
      sreg_r   <= {WIDTH{1'b0}};
      cnt_r    <= 5'h00;
      ld_r     <= 1'b0;
      sck_out  <= 1'b0;
      sdo_out  <= 1'b0;
      ss_out_n <= 1'b1;
    end else if (!on_r) begin
      state_r  <= S_IDLE;
      cnt_r    <= 5'h00;
      ld_r     <= 1'b0;
      sck_out  <= idle_hi;
      ss_out_n <= 1'b1;
    end else begin
      if (tx_pop) begin
        sreg_r  <= txm[tx_rp_r];
        sdo_out <= txm[tx_rp_r][WIDTH-1];
        ld_r    <= ~master;
      end else if (samp_p) begin
        sreg_r <= nxt_word;
      end
      if (chg_p & ~tx_pop) begin
        sdo_out <= sreg_r[WIDTH-1];
      end
      if (run_m & tick & (state_r == S_XFER)) begin
        sck_out <= ~sck_out;
      end
      case (state_r)
        S_IDLE: begin
          cnt_r <= (samp_p & ~master) ? (last ? 5'h00 : cnt_r + 5'h01) : cnt_r;
          if (word_end & ~master) begin
            ld_r <= 1'b0;
          end
          if (~master & ss_en & ss_sy_r[1]) begin
            cnt_r <= 5'h00;
          end
          if (m_load) begin
            state_r  <= S_XFER;
            cnt_r    <= 5'h00;
            ss_out_n <= 1'b0;
          end
          if (master & ~m_load) begin
            sck_out <= idle_hi;
          end
        end
        S_XFER: begin
          if (samp_p) begin
            cnt_r <= cnt_r + 5'h01;
          end
          if (fin) begin
            state_r  <= S_IDLE;
            ss_out_n <= 1'b1;
            cnt_r    <= 5'h00;
          end
          if (!master) begin
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Buffers
  // ----------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (tx_push) begin
      txm[tx_wp_r] <= pwdata[WIDTH-1:0];
    end
    if (rx_push) begin
      rxm[rx_wp_r] <= nxt_word;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_wp_r  <= {AW{1'b0}};
      tx_rp_r  <= {AW{1'b0}};
      tx_cnt_r <= {(AW+1){1'b0}};
      rx_wp_r  <= {AW{1'b0}};
      rx_rp_r  <= {AW{1'b0}};
      rx_cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (tx_push) tx_wp_r <= nxt_ptr(tx_wp_r);
      if (tx_pop)  tx_rp_r <= nxt_ptr(tx_rp_r);
      if (tx_push & ~tx_pop) tx_cnt_r <= tx_cnt_r + 1'b1;
      if (tx_pop & ~tx_push) tx_cnt_r <= tx_cnt_r - 1'b1;
      if (rx_push) rx_wp_r <= nxt_ptr(rx_wp_r);
      if (rx_pop)  rx_rp_r <= nxt_ptr(rx_rp_r);
      if (rx_push & ~rx_pop) rx_cnt_r <= rx_cnt_r + 1'b1;
      if (rx_pop & ~rx_push) rx_cnt_r <= rx_cnt_r - 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Control, status and interrupt registers
  // ----------------------------------------------------------------------------
  // A word that lands on a full receive queue is dropped and flagged.
  wire       ovf_set = word_end & rx_full;
  wire [2:0] ev;
  assign ev[`SPE_EV_DONE] = word_end;
  assign ev[`SPE_EV_OVF]  = ovf_set;
  assign ev[`SPE_EV_TXE]  = tx_pop & (tx_cnt_r == {{AW{1'b0}}, 1'b1}) & ~tx_push;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl1_r <= `SPE_RST_CTRL1;
      ctrl2_r <= `SPE_RST_CTRL2;
      on_r    <= 1'b0;
      ovf_r   <= 1'b0;
      ien_r   <= `SPE_RST_EVT;
      ist_r   <= `SPE_RST_EVT;
      irq     <= 1'b0;
      sck_oe  <= 1'b0;
      sdo_oe  <= 1'b0;
    end else begin
      if (wr & (paddr == `SPE_OFF_CTRL1)) ctrl1_r <= pwdata[15:0];
      if (wr & (paddr == `SPE_OFF_CTRL2)) ctrl2_r <= pwdata[15:0];
      if (wr & (paddr == `SPE_OFF_STAT)) begin
        on_r  <= pwdata[`SPE_ST_ON];
        // Writing zero clears the flag, but a new overflow wins.
        ovf_r <= ovf_set | (ovf_r & pwdata[`SPE_ST_OVF]);
      end else begin
        ovf_r <= ovf_r | ovf_set;
      end
      if (wr & (paddr == `SPE_OFF_IEN)) ien_r <= pwdata[2:0];
      if (wr & (paddr == `SPE_OFF_ICLR)) begin
        ist_r <= ev | (ist_r & ~pwdata[2:0]);
      end else begin
        ist_r <= ist_r | ev;
      end
      irq    <= |(ist_r & ien_r);
      sck_oe <= run_m & ~ctrl1_r[`SPE_C1_SCK_DIS];
      sdo_oe <= on_r & ~ctrl1_r[`SPE_C1_SDO_DIS] & (master | ~ss_en | ~ss_sy_r[1]);
    end
  end

endmodule

`default_nettype wire

// [hdl/spe_dummy_guard.v]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [dv/spe_chk.sv]
// Port checker: APB answer timing and master word framing.
// Assumes software keeps clock idle low and both outputs enabled.
`timescale 1ns/1ps
`default_nettype none
module spe_chk #(
  parameter WIDTH = 8
) (
  input wire        ref_clk,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        sck_out,
  input wire        sck_oe,
  input wire        sdo_oe,
  input wire        ss_out_n,
  input wire        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ------
  // Toggle count
  // ------
  // The last toggle may share its edge with the select release, so it is added at the check.
  reg       sck_d_r;
  reg [7:0] tog_r;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sck_d_r <= 1'b0;
      tog_r   <= 8'h00;
    end else begin
      sck_d_r <= sck_out;
      if (ss_out_n) tog_r <= 8'h00;
      else if (sck_out != sck_d_r) tog_r <= tog_r + 8'h01;
    end
  end
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_ready_latency: assert property (psel && penable && !pready && !$past(penable) |=> pready)
    else $error("pready late after first access cycle");
  chk_err_gated: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_rdata_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  chk_word_toggles: assert property ($rose(ss_out_n) |-> tog_r + (sck_out != sck_d_r) == 2 * WIDTH)
    else $error("wrong clock toggle count in word");
  chk_sck_quiet: assert property (ss_out_n && $past(ss_out_n) |-> $stable(sck_out))
    else $error("serial clock moved outside a word");
  chk_word_driven: assert property (!ss_out_n |-> sck_oe && sdo_oe)
    else $error("word running with pins undriven");
  chk_start_idle: assert property ($fell(ss_out_n) |-> !sck_out ##1 !ss_out_n)
    else $error("word did not start from idle clock");
  cov_word: cover property ($fell(ss_out_n));
  cov_err: cover property (pslverr);
  cov_irq: cover property ($rose(irq));
endmodule
bind spe_port spe_chk #(.WIDTH(WIDTH)) u_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sck_out(sck_out), .sck_oe(sck_oe), .sdo_oe(sdo_oe), .ss_out_n(ss_out_n), .irq(irq));
`default_nettype wire

// [dv/spe_far_slave.sv]
// Far-side serial slave: samples on rising clock, changes on falling.
// Assumes clock idles low and select is active low.
`timescale 1ns/1ps
`default_nettype none
module spe_far_slave #(
  parameter W = 8
) (
  input  wire         sck,
  input  wire         ss_n,
  input  wire         mosi,
  output logic        miso,
  input  wire [W-1:0] tx_word,
  output logic [W-1:0] rx_word
);
  logic [W-1:0] sh_r;
  initial begin
    miso = 1'b0;
    rx_word = '0;
    sh_r = '0;
  end
  always @(negedge ss_n) begin
    sh_r = tx_word;
    miso = tx_word[W-1];
  end
  always @(posedge sck) if (!ss_n) rx_word <= {rx_word[W-2:0], mosi};
  always @(negedge sck) if (!ss_n) begin
    sh_r = sh_r << 1;
    miso = sh_r[W-1];
  end
  // A released line must not keep showing its last bit.
  always @(posedge ss_n) miso = ~miso;
endmodule
`default_nettype wire

// [dv/spe_port_test.sv]
// Testbench of the serial port: APB bring-up, divider timing, master and slave words, events.
// Assumes the far-side slave model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "spe_map.vh"
module spe_port_test;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [7:0]  m_tx    = 8'h00;
  logic        s_mode  = 1'b0;
  logic        s_sck   = 1'b0;
  logic        s_ss_n  = 1'b1;
  logic        s_sdi   = 1'b0;
  logic [7:0]  s_got;
  logic [31:0] q;
  logic        e;
  wire  [31:0] prdata;
  wire         pready, pslverr, sck_out, sck_oe, sdo_out, sdo_oe, ss_out_n, irq, sdi;
  wire  [7:0]  m_rx;
  wire         sdi_mux;
  integer      n_errors  = 0;
  integer      cmp_count = 0;
  logic [1:0]  pv [5] = '{2'h3, 2'h2, 2'h1, 2'h3, 2'h0};
  logic [2:0]  sv [5] = '{3'h7, 3'h6, 3'h7, 3'h0, 3'h7};
  int          nv [5] = '{1, 8, 16, 8, 64};
  always #2.5 ref_clk = ~ref_clk;
  // In slave runs the bench plays the external master on the data input.
  assign sdi_mux = s_mode ? s_sdi : sdi;
  spe_port uut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck_in(s_sck), .sdi_in(sdi_mux), .ss_in_n(s_ss_n),
    .sck_out(sck_out), .sck_oe(sck_oe),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ss_out_n(ss_out_n), .irq(irq));
  spe_far_slave u_far (.sck(sck_out), .ss_n(ss_out_n), .mosi(sdo_out), .miso(sdi),
    .tx_word(m_tx), .rx_word(m_rx));
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    integer k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin @(posedge ref_clk); k++; end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 50) check("pready", 32'h0, 32'h1);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task rd(input logic [7:0] a); apb(1'b0, a, 32'h0); endtask
  task do_reset; rst <= 1'b1; repeat (20) @(posedge ref_clk); rst <= 1'b0; endtask
  // Counts edges until the serial clock changes, bounded.
  task half(output integer t);
    logic s0;
    s0 = sck_out;
    t = 0;
    do begin @(posedge ref_clk); t++; end while (sck_out === s0 && t < 200);
  endtask
  // Plays the external master with the clock idle low: data moves while the clock is low,
  // and the port's output is taken just before each rising edge. Half periods of eight
  // port clocks leave room for the port's two-stage synchronisers and edge detector.
  task sxfer(input logic [7:0] mo, output logic [7:0] got);
    integer b;
    s_ss_n <= 1'b0;
    for (b = 7; b >= 0; b--) begin
      s_sdi <= mo[b];
      repeat (8) @(posedge ref_clk);
      if (b == 7) check("slave_sdo_drive", {31'h0, sdo_oe}, 32'h1);
      got[b] = sdo_out;
      s_sck <= 1'b1;
      repeat (8) @(posedge ref_clk);
      s_sck <= 1'b0;
    end
    repeat (8) @(posedge ref_clk);
    s_ss_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
  initial begin
    #100000;
    n_errors++;
    finish_test;
  end
  initial begin
    integer i, k, t;
    do_reset;
    rd(`SPE_OFF_CTRL1); check("ctrl1_rst", q, 32'h0);
    rd(`SPE_OFF_CTRL2); check("ctrl2_rst", q, 32'h0);
    rd(`SPE_OFF_ISTAT); check("istat_rst", q, 32'h0);
    rd(8'h1C); check("unmapped_err", {31'h0, e}, 32'h1);
    check("unmapped_data", q, 32'h0);
    wr(`SPE_OFF_BUF, 32'h11);
    rd(`SPE_OFF_STAT); check("single_full", {31'h0, q[1]}, 32'h1);
    do_reset;
    wr(`SPE_OFF_CTRL2, 32'h1);
    for (i = 0; i < 7; i++) wr(`SPE_OFF_BUF, i);
    rd(`SPE_OFF_STAT); check("enh_not_full", {31'h0, q[1]}, 32'h0);
    wr(`SPE_OFF_BUF, 32'h7);
    rd(`SPE_OFF_STAT); check("enh_full", {31'h0, q[1]}, 32'h1);
    // Queued words with the port still off must stay put.
    wr(`SPE_OFF_CTRL1, 32'h13F);
    repeat (40) @(posedge ref_clk);
    check("off_idle", {31'h0, ss_out_n}, 32'h1);
    do_reset;
    wr(`SPE_OFF_ICLR, 32'h7);
    wr(`SPE_OFF_IEN, 32'h1);
    for (i = 0; i < 5; i++) begin
      wr(`SPE_OFF_STAT, 32'h0);
      wr(`SPE_OFF_CTRL1, {23'h0, 1'b1, 2'h0, 1'b1, sv[i], pv[i]});
      wr(`SPE_OFF_CTRL2, 32'h1);
      wr(`SPE_OFF_STAT, 32'h8000);
      m_tx <= 8'h3C + i;
      wr(`SPE_OFF_BUF, 32'hA1 + 16 * i);
      repeat (2) @(posedge ref_clk);
      check("start", {31'h0, ss_out_n}, 32'h0);
      check("sck_drive", {31'h0, sck_oe}, 32'h1);
      check("sdo_drive", {31'h0, sdo_oe}, 32'h1);
      half(t);
      half(t);
      check("half_period", t, nv[i]);
      k = 0;
      while (ss_out_n !== 1'b1 && k < 3000) begin @(posedge ref_clk); k++; end
      check("word_end", {31'h0, ss_out_n}, 32'h1);
      check("far_rx", {24'h0, m_rx}, 32'hA1 + 16 * i);
      rd(`SPE_OFF_BUF);
      if (nv[i] >= 8) check("rx_word", q, {24'h0, m_tx});
    end
    check("irq_set", {31'h0, irq}, 32'h1);
    rd(`SPE_OFF_ISTAT); check("istat_done", {31'h0, q[0]}, 32'h1);
    wr(`SPE_OFF_IEN, 32'h0);
    repeat (2) @(posedge ref_clk);
    check("irq_masked", {31'h0, irq}, 32'h0);
    wr(`SPE_OFF_IEN, 32'h1);
    repeat (2) @(posedge ref_clk);
    check("irq_unmasked", {31'h0, irq}, 32'h1);
    wr(`SPE_OFF_ICLR, 32'h7);
    repeat (2) @(posedge ref_clk);
    check("irq_cleared", {31'h0, irq}, 32'h0);
    rd(`SPE_OFF_ISTAT); check("istat_clr", q, 32'h0);
    // Slave bring-up with the select pin in use; one clock pulse comes while deselected
    // and must not shift anything.
    do_reset;
    s_mode <= 1'b1;
    wr(`SPE_OFF_BUF, 32'h0);
    wr(`SPE_OFF_CTRL1, 32'h180);
    wr(`SPE_OFF_STAT, 32'h0);
    wr(`SPE_OFF_CTRL2, 32'h1);
    wr(`SPE_OFF_STAT, 32'h8000);
    wr(`SPE_OFF_BUF, 32'hC3);
    s_sck <= 1'b1;
    repeat (8) @(posedge ref_clk);
    s_sck <= 1'b0;
    repeat (8) @(posedge ref_clk);
    sxfer(8'h96, s_got);
    check("slave_tx0", {24'h0, s_got}, 32'h0);
    sxfer(8'h69, s_got);
    check("slave_tx1", {24'h0, s_got}, 32'hC3);
    rd(`SPE_OFF_BUF); check("slave_rx0", q, 32'h96);
    rd(`SPE_OFF_BUF); check("slave_rx1", q, 32'h69);
    finish_test;
  end
endmodule
`default_nettype wire
